// ---- include/tcu_pkg.sv ----
// Package of constants and types for the timer capture/compare unit
`default_nettype none
package tcu_pkg;
  // ************************************************************
  // Register byte offsets
  // ************************************************************
  localparam logic [11:0] OFS_MODE    = 12'h120;
  localparam logic [11:0] OFS_AB_IO   = 12'h124;
  localparam logic [11:0] OFS_CD_IO   = 12'h128;
  localparam logic [11:0] OFS_CTRL1   = 12'h12c;
  localparam logic [11:0] OFS_OUT_EN  = 12'h130;
  localparam logic [11:0] OFS_COUNTER = 12'h134;
  localparam logic [11:0] OFS_GEN_A   = 12'h138;
  localparam logic [11:0] OFS_GEN_D   = 12'h144;
  localparam logic [11:0] OFS_STATUS  = 12'h148;
  // ************************************************************
  // Reset values and read-as-one mask
  // ************************************************************
  localparam logic [7:0] RST_IO     = 8'h88;
  localparam logic [7:0] RST_MODE   = 8'h00;
  localparam logic [7:0] RST_CTRL1  = 8'h00;
  localparam logic [7:0] RST_OUT_EN = 8'h0f;
  localparam logic [7:0] IO_ONES    = 8'h88;
  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int MODE_RUN    = 0;
  localparam int MODE_BUF_C  = 1;
  localparam int MODE_BUF_D  = 2;
  localparam int MODE_FILTER = 3;
  localparam int CTRL1_CLR   = 7;
  localparam int OUT_EN_CUT  = 7;
  localparam int STAT_OVF    = 4;
  localparam int CTRL1_SRC_LO = 4;
  // ************************************************************
  // Count source codes
  // ************************************************************
  typedef enum logic [2:0] {
    SRC_DIV1 = 3'b000, SRC_DIV2 = 3'b001, SRC_DIV4 = 3'b010,
    SRC_DIV8 = 3'b011, SRC_DIV32 = 3'b100, SRC_EXT = 3'b101,
    SRC_FAST = 3'b110, SRC_NONE = 3'b111
  } tcu_src_t;
  // Per channel nibble of an I/O control register
  typedef struct packed {
    logic       srcPin;
    logic       capture;
    logic [1:0] action;
  } tcu_chcfg_t;
  // External inputs that cross into the clock domain
  typedef struct packed {
    logic       cutoffPin_n;
    logic       slowOsc;
    logic       fastOsc;
    logic       extCount;
    logic [3:0] chanIn;
  } tcu_async_t;
endpackage
`default_nettype wire

// ---- tb/tcu_pin_model.sv ----
// Far side model: pin levels, external count line, cutoff line and oscillators
`timescale 1ns/1ps
`default_nettype none
module tcu_pin_model (
  input  wire logic                core_clk,
  input  wire logic [3:0]          chanOut,
  input  wire logic [3:0]          chanOe,
  input  wire logic [3:0]          pinDrive,
  input  wire logic                extCount,
  input  wire logic                cutoffPin_n,
  output wire tcu_pkg::tcu_async_t asyncIn
);
  logic       slowOsc;
  logic       fastOsc;
  logic [3:0] pinLevel;
  // Oscillators run free, unrelated in phase to the core clock
  initial
  begin
    slowOsc = 1'b0;
    fastOsc = 1'b0;
  end
  always #1283 slowOsc = ~slowOsc;
  always #7 fastOsc = ~fastOsc;
  // Wire level: the unit where it drives, the far side elsewhere
  assign pinLevel = (chanOe & chanOut) | (~chanOe & pinDrive);
  assign asyncIn  = {cutoffPin_n, slowOsc, fastOsc, extCount, pinLevel};
endmodule
`default_nettype wire

// ---- tb/tcu_timer_test.sv ----
// Self-checking testbench for the timer capture/compare unit
`timescale 1ns/1ps
`default_nettype none
module tcu_timer_test;
  logic                core_clk;
  logic                reset_n;
  logic                psel;
  logic                penable;
  logic                pwrite;
  logic [11:0]         paddr;
  logic [31:0]         pwdata;
  logic                pready;
  logic [31:0]         prdata;
  logic                pslverr;
  tcu_pkg::tcu_async_t asyncIn;
  logic [3:0]          chanOut;
  logic [3:0]          chanOe;
  logic [4:0]          eventPulse;
  logic [3:0]          pinDrive;
  logic                extCount;
  logic                cutoffPin_n;
  logic [31:0]         rdData;
  logic                rdErr;
  logic [4:0]          seen;
  int                  failCount;
  int                  checked;

  tcu_timer tcu_timer_inst (
    .core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .asyncIn(asyncIn), .chanOut(chanOut), .chanOe(chanOe), .eventPulse(eventPulse));
  tcu_pin_model tcu_pin_model_inst (
    .core_clk(core_clk), .chanOut(chanOut), .chanOe(chanOe), .pinDrive(pinDrive),
    .extCount(extCount), .cutoffPin_n(cutoffPin_n), .asyncIn(asyncIn));

  // ************************************************************
  // Helpers
  // ************************************************************
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
      begin
        failCount++;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
  endtask

  // One APB transfer, held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    chk(32'(n < 20), 32'h1);
    rdData = prdata;
    rdErr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdData, exp);
  endtask

  // Gathers event pulses until all of mask are seen or lim cycles pass
  task automatic waitEvt(input logic [4:0] mask, input int lim);
    seen = 5'h00;
    for (int i = 0; i < lim && (seen & mask) != mask; i++)
    begin
      @(negedge core_clk);
      seen = seen | eventPulse;
    end
    @(posedge core_clk);
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic tRegs;
    rdc(tcu_pkg::OFS_AB_IO, 32'h88);
    rdc(tcu_pkg::OFS_CD_IO, 32'h88);
    rdc(tcu_pkg::OFS_OUT_EN, 32'h0f);
    rdc(tcu_pkg::OFS_GEN_A, 32'hffff);
    rdc(tcu_pkg::OFS_MODE, 32'h0);
    apb(1'b0, 12'h200, 32'h0);
    chk(32'(rdErr), 32'h1);
    chk(rdData, 32'h0);
    wr(tcu_pkg::OFS_AB_IO, 32'h0);      // Bit seven written as zero
    rdc(tcu_pkg::OFS_AB_IO, 32'h80);
  endtask

  task automatic tSources;
    logic [31:0] got;
    int          e;
    for (int k = 0; k < 5; k++)
    begin
      wr(tcu_pkg::OFS_MODE, 32'h0);
      wr(tcu_pkg::OFS_CTRL1, 32'(k) << 4);
      wr(tcu_pkg::OFS_COUNTER, 32'h0);
      wr(tcu_pkg::OFS_MODE, 32'h1);
      cycles(128);
      wr(tcu_pkg::OFS_MODE, 32'h0);
      apb(1'b0, tcu_pkg::OFS_COUNTER, 32'h0);
      got = rdData;
      e = 128 >> ((k == 4) ? 5 : k);
      chk(32'(got >= e && got <= e + 8), 32'h1);
      cycles(10);
      rdc(tcu_pkg::OFS_COUNTER, got);
    end
    wr(tcu_pkg::OFS_CTRL1, 32'h50);
    wr(tcu_pkg::OFS_COUNTER, 32'h0);
    wr(tcu_pkg::OFS_MODE, 32'h1);
    repeat (10)
    begin
      extCount <= 1'b1;
      cycles(4);
      extCount <= 1'b0;
      cycles(4);
    end
    cycles(8);
    wr(tcu_pkg::OFS_MODE, 32'h0);
    rdc(tcu_pkg::OFS_COUNTER, 32'd10);
    wr(tcu_pkg::OFS_CTRL1, 32'h0);
  endtask

  task automatic tCompare;
    logic init;
    logic lvl;
    for (int act = 0; act < 4; act++)
    begin
      init = (act == 1);
      wr(tcu_pkg::OFS_MODE, 32'h0);
      wr(tcu_pkg::OFS_OUT_EN, 32'h0);
      wr(tcu_pkg::OFS_AB_IO, 32'h08 | 32'(act));
      wr(tcu_pkg::OFS_CTRL1, 32'(init));
      wr(tcu_pkg::OFS_COUNTER, 32'h0);
      wr(tcu_pkg::OFS_GEN_A, 32'h40);
      wr(tcu_pkg::OFS_MODE, 32'h1);
      @(negedge core_clk);
      chk(32'(chanOe[0]), 32'(act != 0));
      if (act != 0)
        chk(32'(chanOut[0]), 32'(init));
      @(posedge core_clk);
      waitEvt(5'h01, 120);
      chk(32'(seen[0]), 32'h1);
      cycles(3);
      @(negedge core_clk);
      if (act != 0)
        chk(32'(chanOut[0]), 32'(act != 1));
      @(posedge core_clk);
      wr(tcu_pkg::OFS_MODE, 32'h0);
      lvl = chanOut[0];
      cycles(20);
      chk(32'(chanOut[0]), 32'(lvl));
      apb(1'b0, tcu_pkg::OFS_STATUS, 32'h0);
      chk(32'(rdData[0]), 32'h1);
      wr(tcu_pkg::OFS_STATUS, 32'h1f);
      rdc(tcu_pkg::OFS_STATUS, 32'h0);
    end
  endtask

  task automatic tClearOvf;
    wr(tcu_pkg::OFS_CTRL1, 32'h80);
    wr(tcu_pkg::OFS_COUNTER, 32'h0);
    wr(tcu_pkg::OFS_MODE, 32'h1);
    repeat (6)
    begin
      cycles(23);
      apb(1'b0, tcu_pkg::OFS_COUNTER, 32'h0);
      chk(32'(rdData <= 32'h40), 32'h1);
    end
    wr(tcu_pkg::OFS_MODE, 32'h0);
    wr(tcu_pkg::OFS_CTRL1, 32'h0);
    wr(tcu_pkg::OFS_COUNTER, 32'hfff0);
    wr(tcu_pkg::OFS_MODE, 32'h1);
    waitEvt(5'h10, 40);
    chk(32'(seen[4]), 32'h1);
    apb(1'b0, tcu_pkg::OFS_COUNTER, 32'h0);
    chk(32'(rdData < 32'h40), 32'h1);
    apb(1'b0, tcu_pkg::OFS_STATUS, 32'h0);
    chk(32'(rdData[4]), 32'h1);
  endtask

  task automatic tCapture;
    logic [31:0] cap;
    logic [3:0]  r;
    logic [3:0]  f;
    wr(tcu_pkg::OFS_OUT_EN, 32'h0f);
    wr(tcu_pkg::OFS_MODE, 32'h1);
    for (int c = 0; c < 4; c++)
    begin
      wr(tcu_pkg::OFS_AB_IO, 32'h4c | (32'(c) << 4) | 32'(c));
      wr(tcu_pkg::OFS_CD_IO, 32'h40 | (32'(c) << 4));
      cycles(8);
      pinDrive <= 4'hb;
      waitEvt(5'h0b, 20);
      r = seen[3:0] & 4'hb;
      if (c == 0)
      begin
        apb(1'b0, tcu_pkg::OFS_GEN_A, 32'h0);
        cap = rdData;
        apb(1'b0, tcu_pkg::OFS_COUNTER, 32'h0);
        chk(32'(rdData - cap < 60), 32'h1);
      end
      pinDrive <= 4'h0;
      waitEvt(5'h0b, 20);
      f = seen[3:0] & 4'hb;
      chk(32'(r), (c == 0 || c == 2) ? 32'hb : 32'h0);
      chk(32'(f), (c == 1 || c == 2) ? 32'hb : 32'h0);
    end
    wr(tcu_pkg::OFS_AB_IO, 32'h06);
    waitEvt(5'h01, 100);
    chk(32'(seen[0]), 32'h1);
    wr(tcu_pkg::OFS_MODE, 32'h3);
    wr(tcu_pkg::OFS_CD_IO, 32'h04);   // Buffer channel matches A's function
    wr(tcu_pkg::OFS_AB_IO, 32'h0c);
    pinDrive <= 4'h1;
    waitEvt(5'h01, 20);
    pinDrive <= 4'h0;
    apb(1'b0, tcu_pkg::OFS_GEN_A, 32'h0);
    cap = rdData;
    cycles(30);
    pinDrive <= 4'h1;
    waitEvt(5'h01, 20);
    rdc(tcu_pkg::OFS_GEN_A + 12'h008, cap);
    pinDrive <= 4'h0;
    wr(tcu_pkg::OFS_MODE, 32'h9);
    wr(tcu_pkg::OFS_AB_IO, 32'h0c);
    pinDrive <= 4'h1;
    cycles(2);
    pinDrive <= 4'h0;
    waitEvt(5'h01, 20);
    chk(32'(seen[0]), 32'h0);
    pinDrive <= 4'h1;
    waitEvt(5'h01, 20);
    chk(32'(seen[0]), 32'h1);
    pinDrive <= 4'h0;
    wr(tcu_pkg::OFS_MODE, 32'h0);
  endtask

  task automatic tCutoff;
    wr(tcu_pkg::OFS_AB_IO, 32'h0a);
    wr(tcu_pkg::OFS_OUT_EN, 32'h80);
    @(negedge core_clk);
    chk(32'(chanOe[0]), 32'h1);
    @(posedge core_clk);
    cutoffPin_n <= 1'b0;
    cycles(8);
    @(negedge core_clk);
    chk(32'(chanOe), 32'h0);
    @(posedge core_clk);
    cutoffPin_n <= 1'b1;
    rdc(tcu_pkg::OFS_OUT_EN, 32'h8f);
  endtask

  // ************************************************************
  // Run control
  // ************************************************************
  task automatic finishTest;
    $display("Comparisons %0d, mismatches %0d", checked, failCount);
    if (failCount == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    #2000000;
    failCount++;
    $display("[ERR] %0t watchdog expired", $time);
    finishTest;
  end

  initial
  begin
    failCount   = 0;
    checked     = 0;
    reset_n     = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 12'h000;
    pwdata      = 32'h0;
    pinDrive    = 4'h0;
    extCount    = 1'b0;
    cutoffPin_n = 1'b1;
    cycles(6);
    reset_n <= 1'b1;
    @(posedge core_clk);
    tRegs;
    tSources;
    tCompare;
    tClearOvf;
    tCapture;
    tCutoff;
    finishTest;
  end
endmodule
`default_nettype wire

// ---- verilog/tcu_timer.sv ----
// Timer capture/compare unit with APB register access
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RULE_01: Counter increments on selected count source
// RULE_02: Capture edge copies counter into channel register
// RULE_03: Capture mode counter spans full 16 bits
// RULE_04: Run bit starts, clear stops, value kept
// RULE_05: Capture events and overflow raise requests
// RULE_06: Channel A edge: rise, fall, both
// RULE_07: Channels B and D same edge coding
// RULE_08: Function bit: one capture, zero compare
// RULE_09: Channel A source: slow oscillator or pin
// RULE_10: Software matches buffer channel function bits
// RULE_11: Buffered capture moves old value first
// RULE_12: Compare match drives pin to level
// RULE_13: Channel A action: off, low, high, toggle
// RULE_14: Channel B action uses same coding
// RULE_15: Clear bit resets counter on A match
// RULE_16: Compare matches and overflow raise requests
// RULE_17: Stopped compare holds pins and count
// RULE_18: Initial level driven until first match
// RULE_19: Counter readable and writable any time
// RULE_20: Each pin individually general or timer
// RULE_21: Internal timer works with outputs off
// RULE_22: Unassigned control bit seven reads one
// RULE_23: Cutoff low sets all output disable bits
// RULE_24: Filter accepts after three equal samples
// RULE_25: Overflow wraps to zero and continues
module tcu_timer #(
  parameter int CW = 16
) (
  input  wire logic               core_clk,
  input  wire logic               reset_n,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic                    pready,
  output logic [31:0]             prdata,
  output logic                    pslverr,
  input  wire tcu_pkg::tcu_async_t asyncIn,
  output logic [3:0]              chanOut,
  output logic [3:0]              chanOe,
  output logic [4:0]              eventPulse
);
  // ************************************************************
  // Registers and nets
  // ************************************************************
  logic [7:0]          mode_reg, abIo_reg, cdIo_reg, ctrl1_reg, outEn_reg;
  logic [4:0]          status_reg;
  logic [CW-1:0]       count_reg;
  logic [CW-1:0]       gen_reg [4];
  logic [3:0]          level_reg;
  logic [4:0]          divCnt_reg;
  logic [7:0]          stable;
  logic [3:0]          chanLvl, rise, fall;
  logic [1:0]          oscPrev_reg;
  logic [3:0]          chanPrev_reg;
  logic                extPrev_reg, runPrev_reg;
  tcu_pkg::tcu_chcfg_t cfg [4];
  logic [3:0]          isBuf, capEv, cmpEv;
  logic                tick, ovf, clrA, apbWr, apbRd, hit;
  logic [31:0]         rdMux;
  logic [2:0]          src;

  // Channel fields out of the two I/O control registers
  assign cfg[0] = tcu_pkg::tcu_chcfg_t'(abIo_reg[3:0]);
  assign cfg[1] = tcu_pkg::tcu_chcfg_t'(abIo_reg[7:4]);
  assign cfg[2] = tcu_pkg::tcu_chcfg_t'(cdIo_reg[3:0]);
  assign cfg[3] = tcu_pkg::tcu_chcfg_t'(cdIo_reg[7:4]);
  assign isBuf  = {mode_reg[tcu_pkg::MODE_BUF_D], mode_reg[tcu_pkg::MODE_BUF_C], 2'b00};

  // ************************************************************
  // Input synchronisers and digital filter
  // ************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_in
      logic s1, s2, s3, stab;
      logic [2:0] hist;
      // Three flops; a change counts once the last two agree
      always_ff @(posedge core_clk)
      begin
        if (!reset_n)
        begin
          s1 <= 1'b1;
          s2 <= 1'b1;
          s3 <= 1'b1;
          stab <= 1'b1;
        end
        else
        begin
          s1 <= asyncIn[gi];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3)
            stab <= s3;
        end
      end
      // Three equal samples before a channel level is taken
      always_ff @(posedge core_clk)
      begin
        if (!reset_n)
          hist <= 3'b111;
        else
          hist <= {hist[1:0], stab};
      end
      if (gi < 4)
      begin : g_chan
        assign stable[gi] = !mode_reg[tcu_pkg::MODE_FILTER] ? stab :
                            (hist == 3'b111) ? 1'b1 :
                            (hist == 3'b000) ? 1'b0 : chanLvl[gi]; // [RULE_24]
      end
      else
      begin : g_misc
        assign stable[gi] = stab;
      end
    end
  endgenerate

  // Filtered channel level holds between decisions
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      chanLvl <= 4'hf;
    else
      chanLvl <= stable[3:0];
  end

  // Previous samples for edge detection
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      chanPrev_reg <= 4'hf;
      oscPrev_reg  <= 2'b11;
      extPrev_reg  <= 1'b1;
      runPrev_reg  <= 1'b0;
    end
    else
    begin
      chanPrev_reg <= chanLvl;
      oscPrev_reg  <= stable[6:5];
      extPrev_reg  <= stable[4];
      runPrev_reg  <= mode_reg[tcu_pkg::MODE_RUN];
    end
  end

  // ************************************************************
  // Count source and counter
  // ************************************************************
  // Free running prescaler for the divided system clock
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      divCnt_reg <= 5'h00;
    else
      divCnt_reg <= divCnt_reg + 5'h01;
  end

  assign src = ctrl1_reg[tcu_pkg::CTRL1_SRC_LO +: 3];
  // One-cycle count enable from the selected source
  always_comb
  begin
    case (tcu_pkg::tcu_src_t'(src)) // [RULE_01]
      tcu_pkg::SRC_DIV1:  tick = 1'b1;
      tcu_pkg::SRC_DIV2:  tick = divCnt_reg[0];
      tcu_pkg::SRC_DIV4:  tick = &divCnt_reg[1:0];
      tcu_pkg::SRC_DIV8:  tick = &divCnt_reg[2:0];
      tcu_pkg::SRC_DIV32: tick = &divCnt_reg;
      tcu_pkg::SRC_EXT:   tick = stable[4] & !extPrev_reg;
      tcu_pkg::SRC_FAST:  tick = stable[5] & !oscPrev_reg[0];
      default:            tick = 1'b0;
    endcase
  end

  assign apbWr = psel & penable & pready & pwrite;
  assign apbRd = psel & penable & !pready & !pwrite;
  assign ovf   = mode_reg[tcu_pkg::MODE_RUN] & tick & (&count_reg);
  assign clrA  = cmpEv[0] & ctrl1_reg[tcu_pkg::CTRL1_CLR];

  // Counter: software write, A-match clear, else increment
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      count_reg <= '0;
    else if (apbWr && paddr == tcu_pkg::OFS_COUNTER)
      count_reg <= pwdata[CW-1:0]; // [RULE_19]
    else if (clrA)
      count_reg <= '0; // [RULE_15]
    else if (mode_reg[tcu_pkg::MODE_RUN] && tick)
      count_reg <= count_reg + 1'b1; // [RULE_01] [RULE_03] [RULE_25]
  end

  // ************************************************************
  // Capture and compare events per channel
  // ************************************************************
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_ev
      logic edgeIn, rs, fl;
      // Channel A may take the slow oscillator instead of its pin
      assign rs = (gi == 0 && !cfg[0].srcPin) ? (stable[6] & !oscPrev_reg[1])
                                               : (chanLvl[gi] & !chanPrev_reg[gi]); // [RULE_09]
      assign fl = (gi == 0 && !cfg[0].srcPin) ? (!stable[6] & oscPrev_reg[1])
                                               : (!chanLvl[gi] & chanPrev_reg[gi]);
      assign rise[gi] = rs;
      assign fall[gi] = fl;
      // Edge code: 00 rising, 01 falling, 10 both
      assign edgeIn = (cfg[gi].action == 2'b00) ? rs :
                      (cfg[gi].action == 2'b01) ? fl :
                      (cfg[gi].action == 2'b10) ? (rs | fl) : 1'b0; // [RULE_06] [RULE_07]
      assign capEv[gi] = cfg[gi].capture & edgeIn & !isBuf[gi]; // [RULE_08] [RULE_02]
      assign cmpEv[gi] = !cfg[gi].capture & !isBuf[gi] & mode_reg[tcu_pkg::MODE_RUN] & tick
                         & (count_reg == gen_reg[gi]); // [RULE_12] [RULE_21]
    end
  endgenerate

  // General registers: software write, capture, buffer transfer
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < 4; i++)
        gen_reg[i] <= '1;
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (apbWr && paddr == tcu_pkg::OFS_GEN_A + 12'(4 * i))
          gen_reg[i] <= pwdata[CW-1:0];
      end
      for (int i = 0; i < 2; i++)
      begin
        if (capEv[i])
        begin
          gen_reg[i] <= count_reg; // [RULE_02]
          if (isBuf[i + 2])
            gen_reg[i + 2] <= gen_reg[i]; // [RULE_11]
        end
        else if (cmpEv[i] && isBuf[i + 2])
          gen_reg[i] <= gen_reg[i + 2];
      end
      for (int i = 2; i < 4; i++)
      begin
        if (capEv[i])
          gen_reg[i] <= count_reg;
      end
    end
  end

  // ************************************************************
  // Compare outputs
  // ************************************************************
  // Level: initial on start or control write, action on match
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      level_reg <= 4'h0;
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        if ((mode_reg[tcu_pkg::MODE_RUN] && !runPrev_reg) ||
            (apbWr && paddr == tcu_pkg::OFS_CTRL1))
          level_reg[i] <= (apbWr && paddr == tcu_pkg::OFS_CTRL1) ? pwdata[i] : ctrl1_reg[i]; // [RULE_18]
        else if (cmpEv[i])
        begin
          case (cfg[i].action) // [RULE_13] [RULE_14]
            2'b01:   level_reg[i] <= 1'b0;
            2'b10:   level_reg[i] <= 1'b1;
            2'b11:   level_reg[i] <= !level_reg[i];
            default: level_reg[i] <= level_reg[i];
          endcase
        end
      end
    end
  end

  // Pins driven from flops; enable only for active compare outputs
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      chanOut <= 4'h0;
      chanOe  <= 4'h0;
    end
    else
    begin
      chanOut <= level_reg; // [RULE_17]
      for (int i = 0; i < 4; i++)
        chanOe[i] <= !cfg[i].capture & (cfg[i].action != 2'b00) & !isBuf[i]
                     & !outEn_reg[i]; // [RULE_20] [RULE_13]
    end
  end

  // Event pulses and sticky status; set wins over clear
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      eventPulse <= 5'h00;
      status_reg <= 5'h00;
    end
    else
    begin
      eventPulse <= {ovf, capEv | cmpEv}; // [RULE_05] [RULE_16]
      status_reg <= (status_reg & ~((apbWr && paddr == tcu_pkg::OFS_STATUS) ? pwdata[4:0] : 5'h00))
                    | {ovf, capEv | cmpEv};
    end
  end

  // ************************************************************
  // Control registers over APB
  // ************************************************************
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      mode_reg  <= tcu_pkg::RST_MODE;
      abIo_reg  <= tcu_pkg::RST_IO;
      cdIo_reg  <= tcu_pkg::RST_IO;
      ctrl1_reg <= tcu_pkg::RST_CTRL1;
    end
    else if (apbWr)
    begin
      case (paddr)
        tcu_pkg::OFS_MODE:  mode_reg  <= pwdata[7:0]; // [RULE_04]
        tcu_pkg::OFS_AB_IO: abIo_reg  <= pwdata[7:0];
        tcu_pkg::OFS_CD_IO: cdIo_reg  <= pwdata[7:0];
        tcu_pkg::OFS_CTRL1: ctrl1_reg <= pwdata[7:0];
        default:            mode_reg  <= mode_reg;
      endcase
    end
  end

  // Output disable bits; cutoff sets all four and wins
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      outEn_reg <= tcu_pkg::RST_OUT_EN;
    else
    begin
      if (apbWr && paddr == tcu_pkg::OFS_OUT_EN)
        outEn_reg <= pwdata[7:0];
      if (outEn_reg[tcu_pkg::OUT_EN_CUT] && !stable[7])
        outEn_reg[3:0] <= 4'hf; // [RULE_23]
    end
  end

  // Read multiplexer and decode
  always_comb
  begin
    hit   = 1'b1;
    rdMux = 32'h0000_0000;
    case (paddr)
      tcu_pkg::OFS_MODE:    rdMux[7:0] = mode_reg;
      tcu_pkg::OFS_AB_IO:   rdMux[7:0] = abIo_reg | 8'h80; // [RULE_22]
      tcu_pkg::OFS_CD_IO:   rdMux[7:0] = cdIo_reg | tcu_pkg::IO_ONES; // [RULE_22]
      tcu_pkg::OFS_CTRL1:   rdMux[7:0] = ctrl1_reg;
      tcu_pkg::OFS_OUT_EN:  rdMux[7:0] = outEn_reg;
      tcu_pkg::OFS_COUNTER: rdMux[CW-1:0] = count_reg; // [RULE_19]
      tcu_pkg::OFS_STATUS:  rdMux[4:0] = status_reg;
      default:
      begin
        hit = 1'b0;
        for (int i = 0; i < 4; i++)
        begin
          if (paddr == tcu_pkg::OFS_GEN_A + 12'(4 * i))
          begin
            hit = 1'b1;
            rdMux[CW-1:0] = gen_reg[i];
          end
        end
      end
    endcase
  end

  // One wait state: ready in the second access cycle
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel & penable & !pready;
      pslverr <= psel & penable & !pready & !hit;
      if (apbRd)
        prdata <= hit ? rdMux : 32'h0000_0000;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  property p_stop_hold;
    !mode_reg[tcu_pkg::MODE_RUN] && !apbWr |=> $stable(count_reg) && $stable(level_reg);
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("count moved while stopped"); // [RULE_04] [RULE_17]

  property p_inc;
    mode_reg[tcu_pkg::MODE_RUN] && tick && !clrA && !apbWr |=> count_reg == $past(count_reg) + 1'b1;
  endproperty
  a_inc: assert property (p_inc) else $error("counter did not increment"); // [RULE_01]

  property p_wrap;
    ovf && !clrA && !apbWr |=> count_reg == '0 && eventPulse[tcu_pkg::STAT_OVF];
  endproperty
  a_wrap: assert property (p_wrap) else $error("overflow did not wrap"); // [RULE_25] [RULE_05]

  property p_clear;
    clrA && !apbWr |=> count_reg == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("A match did not clear counter"); // [RULE_15]

  property p_capture;
    capEv[1] && !apbWr |=> gen_reg[1] == $past(count_reg);
  endproperty
  a_capture: assert property (p_capture) else $error("capture value wrong"); // [RULE_02]

  property p_buffer;
    capEv[0] && isBuf[2] |=> gen_reg[2] == $past(gen_reg[0]);
  endproperty
  a_buffer: assert property (p_buffer) else $error("buffer not moved"); // [RULE_11]

  property p_high;
    cmpEv[0] && cfg[0].action == 2'b10 && !apbWr && runPrev_reg |=> ##1 chanOut[0];
  endproperty
  a_high: assert property (p_high) else $error("high action not driven"); // [RULE_13]

  property p_cutoff;
    outEn_reg[tcu_pkg::OUT_EN_CUT] && !stable[7] |=> outEn_reg[3:0] == 4'hf ##1 chanOe == 4'h0;
  endproperty
  a_cutoff: assert property (p_cutoff) else $error("cutoff did not disable"); // [RULE_23]

  property p_bit7;
    apbRd && paddr == tcu_pkg::OFS_AB_IO |=> prdata[7];
  endproperty
  a_bit7: assert property (p_bit7) else $error("bit seven not one"); // [RULE_22]

  property p_match_flag;
    cmpEv[3] |=> status_reg[3] && eventPulse[3];
  endproperty
  a_match_flag: assert property (p_match_flag) else $error("match flag lost"); // [RULE_16] [RULE_21]
endmodule
`default_nettype wire
